/* File: verilog/rcm_top.sv */
// Calendar registers, running calendar and alarm behind an APB slave.
// Assumes APB signals are synchronous to core_clk; slow_clock is a pin.
`timescale 1ns/1ps
`include "rcm_cfg.svh"

// What this block does
// RULE1: Weekday alarm zero ignores weekday
// RULE2: Weekday alarm 1-7 must equal weekday
// RULE3: Month-day alarm zero ignores month-day
// RULE4: Month-day alarm 1-31 must equal day
// RULE5: Month alarm zero ignores month
// RULE6: Month alarm 1-12 must equal month
// RULE7: Month alarm 13-15 never matches
// RULE8: Software presets seconds, minutes 0-59
// RULE9: Software presets hour 0-23 only
// RULE10: Preset weekday codes 1-7, never zero
// RULE11: Software presets day within month length
// RULE12: Software presets month codes 1-12
// RULE13: Current year read-only BCD, resets 0x2000
// RULE14: Year alarm writable BCD, resets 0x2000
// RULE15: Year preset writable BCD, resets zero
// RULE16: Invalid second, minute, hour alarms never match
// RULE17: Enable starts calendar, locks control register
// RULE18: Alarm match sets raw status bit
// RULE19: Alarm needs all included fields equal
// RULE20: Enabling copies presets into calendar counters
module rcm_top (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        slow_clock,
  output logic             calendar_enable,
  output logic             one_hz_tick,
  output logic             alarm_event
);
  // Software-visible storage
  logic [28:0] alarm_reg;
  logic [28:0] preset_reg;
  logic [13:0] alyear_reg;
  logic [13:0] pryear_reg;
  logic [14:0] ckdiv_reg;
  logic [9:0]  ckdel_reg;
  logic        ris_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        en_reg;

  // Running calendar
  rcm_pkg::rcm_state_t st_reg;
  rcm_pkg::rcm_state_t st_next;
  logic [5:0]  sec_reg;
  logic [5:0]  min_reg;
  logic [4:0]  hour_reg;
  logic [2:0]  wday_reg;
  logic [4:0]  mday_reg;
  logic [3:0]  month_reg;
  logic [13:0] year_reg;
  logic        upd_reg;
  logic [5:0]  sec_next;
  logic [5:0]  min_next;
  logic [4:0]  hour_next;
  logic [2:0]  wday_next;
  logic [4:0]  mday_next;
  logic [3:0]  month_next;
  logic [13:0] year_next;

  // Bus decode
  logic        setup;
  logic        wr_go;
  logic        hit_alarm;
  logic        hit_preset;
  logic        hit_year;
  logic        hit_alyear;
  logic        hit_pryear;
  logic        hit_ctrl;
  logic        hit_ris;
  logic        hit_icr;
  logic        hit_now;
  logic        mapped;
  logic [31:0] rd_mux;
  logic [31:0] now_word;
  logic [31:0] ctrl_word;

  // Calendar carries
  logic        tick;
  logic        run;
  logic        hit;
  logic        c_sec;
  logic        c_min;
  logic        c_hour;
  logic        c_day;
  logic        c_mon;
  logic [4:0]  dim;
  logic [2:0]  pre_wday;

  rcm_cal_if cal ();

  // Leap year from a BCD year, century years checked on the upper pair
  function automatic logic div4(input logic [3:0] t, input logic [3:0] u);
    div4 = t[0] ? ((u == 4'h2) || (u == 4'h6))
                : ((u == 4'h0) || (u == 4'h4) || (u == 4'h8));
  endfunction

  function automatic logic leap(input logic [13:0] y);
    leap = (y[7:0] != 8'h00) ? div4(y[7:4], y[3:0])
                             : div4({2'b00, y[13:12]}, y[11:8]);
  endfunction

  // Days in the running month
  function automatic logic [4:0] month_len(input logic [3:0] m,
                                           input logic [13:0] y);
    case (m)
      4'h2:                      month_len = leap(y) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB:    month_len = 5'h1E;
      default:                   month_len = 5'h1F;
    endcase
  endfunction

  // BCD increment; the top digit has only two bits and wraps silently
  function automatic logic [13:0] bcd_inc(input logic [13:0] y);
    logic [15:0] d;
    logic        c;
    d = {2'b00, y};
    c = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (c) begin
        if (d[i*4 +: 4] == 4'h9) begin
          d[i*4 +: 4] = 4'h0;
        end else begin
          d[i*4 +: 4] = d[i*4 +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    bcd_inc = d[13:0];
  endfunction

  // APB decode: answer is ready in the first access cycle
  assign setup      = psel & ~penable;
  assign wr_go      = psel & penable & pwrite & pready_reg;
  assign hit_now    = (paddr == `RCM_OFS_NOW);
  assign hit_alarm  = (paddr == `RCM_OFS_ALARM);
  assign hit_preset = (paddr == `RCM_OFS_PRESET);
  assign hit_year   = (paddr == `RCM_OFS_YEAR);
  assign hit_alyear = (paddr == `RCM_OFS_ALYEAR);
  assign hit_pryear = (paddr == `RCM_OFS_PRYEAR);
  assign hit_ctrl   = (paddr == `RCM_OFS_CTRL);
  assign hit_ris    = (paddr == `RCM_OFS_RIS);
  assign hit_icr    = (paddr == `RCM_OFS_ICR);
  assign mapped     = hit_now | hit_alarm | hit_preset | hit_year |
                      hit_alyear | hit_pryear | hit_ctrl | hit_ris |
                      hit_icr;

  // Read words; reserved bits read as zero
  assign now_word  = {3'b000, month_reg, mday_reg, wday_reg, hour_reg,
                      min_reg, sec_reg};
  assign ctrl_word = {5'b00000, en_reg, ckdel_reg, 1'b0, ckdiv_reg};
  assign rd_mux =
    hit_now    ? now_word                   :
    hit_alarm  ? {3'b000, alarm_reg}        :
    hit_preset ? {3'b000, preset_reg}       :
    hit_year   ? {18'h00000, year_reg}      : // RULE13
    hit_alyear ? {18'h00000, alyear_reg}    :
    hit_pryear ? {18'h00000, pryear_reg}    :
    hit_ctrl   ? ctrl_word                  :
    hit_ris    ? {31'h00000000, ris_reg}    :
                 32'h00000000;

  // Bus answer registers, loaded in the setup cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~mapped;
      if (setup) prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  // Alarm and preset storage
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      alarm_reg  <= 29'h00000000; // RULE1 RULE3 RULE5
      preset_reg <= 29'h00000000;
      alyear_reg <= `RCM_ALYEAR_RST; // RULE14
      pryear_reg <= `RCM_PRYEAR_RST; // RULE15
    end else if (wr_go) begin
      if (hit_alarm)  alarm_reg  <= pwdata[28:0];
      if (hit_preset) preset_reg <= pwdata[28:0];
      if (hit_alyear) alyear_reg <= pwdata[`RCM_F_YEAR]; // RULE14
      if (hit_pryear) pryear_reg <= pwdata[`RCM_F_YEAR]; // RULE15
    end
  end

  // Control word: once enabled, only a reset unlocks it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ckdiv_reg <= `RCM_CKDIV_RST;
      ckdel_reg <= `RCM_CKDEL_RST;
      en_reg    <= 1'b0;
    end else if (wr_go && hit_ctrl && !en_reg) begin // RULE17
      ckdiv_reg <= pwdata[`RCM_F_CKDIV];
      ckdel_reg <= pwdata[`RCM_F_CKDEL];
      en_reg    <= pwdata[`RCM_B_ENABLE];
    end
  end

  // Raw status: a match in the clearing cycle still sets the bit
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) ris_reg <= 1'b0;
    else if (hit) ris_reg <= 1'b1; // RULE18
    else if (wr_go && hit_icr && pwdata[`RCM_B_RIS]) ris_reg <= 1'b0;
  end

  // Sequencer: stopped, one load cycle, then running
  always_comb begin
    case (st_reg)
      rcm_pkg::RCM_STOP: st_next = en_reg ? rcm_pkg::RCM_LOAD
                                          : rcm_pkg::RCM_STOP;
      rcm_pkg::RCM_LOAD: st_next = rcm_pkg::RCM_RUN;
      rcm_pkg::RCM_RUN:  st_next = rcm_pkg::RCM_RUN;
      default:           st_next = rcm_pkg::RCM_STOP;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) st_reg <= rcm_pkg::RCM_STOP;
    else st_reg <= st_next; // RULE17
  end

  assign run = (st_reg == rcm_pkg::RCM_RUN);

  // Carry chain of the running calendar
  assign dim    = month_len(month_reg, year_reg);
  assign c_sec  = (sec_reg == `RCM_SEC_MAX);
  assign c_min  = c_sec & (min_reg == `RCM_SEC_MAX);
  assign c_hour = c_min & (hour_reg == `RCM_HOUR_MAX);
  assign c_day  = c_hour & (mday_reg >= dim);
  assign c_mon  = c_day & (month_reg >= `RCM_MON_MAX);

  assign sec_next   = c_sec ? 6'h00 : sec_reg + 6'h01;
  assign min_next   = !c_sec ? min_reg : (c_min ? 6'h00 : min_reg + 6'h01);
  assign hour_next  = !c_min ? hour_reg
                             : (c_hour ? 5'h00 : hour_reg + 5'h01);
  assign wday_next  = !c_hour ? wday_reg
                    : ((wday_reg == `RCM_WDAY_MAX) ? 3'h1
                                                   : wday_reg + 3'h1);
  assign mday_next  = !c_hour ? mday_reg
                              : (c_day ? 5'h01 : mday_reg + 5'h01);
  assign month_next = !c_day ? month_reg
                             : (c_mon ? 4'h1 : month_reg + 4'h1);
  assign year_next  = c_mon ? bcd_inc(year_reg) : year_reg;

  // A zero weekday preset is not a valid weekday code, so use Sunday
  assign pre_wday = (preset_reg[`RCM_F_WDAY] == 3'h0) ? 3'h1
                                                      : preset_reg[`RCM_F_WDAY];

  // Calendar counters: preset on load, advance on each one second tick
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sec_reg   <= 6'h00;
      min_reg   <= 6'h00;
      hour_reg  <= 5'h00;
      wday_reg  <= 3'h1;
      mday_reg  <= 5'h01;
      month_reg <= 4'h1;
      year_reg  <= `RCM_YEAR_RST; // RULE13
    end else if (st_reg == rcm_pkg::RCM_LOAD) begin // RULE20
      sec_reg   <= preset_reg[`RCM_F_SEC];
      min_reg   <= preset_reg[`RCM_F_MIN];
      hour_reg  <= preset_reg[`RCM_F_HOUR];
      wday_reg  <= pre_wday; // RULE10
      mday_reg  <= preset_reg[`RCM_F_MDAY];
      month_reg <= preset_reg[`RCM_F_MONTH];
      year_reg  <= pryear_reg;
    end else if (run && tick) begin
      sec_reg   <= sec_next;
      min_reg   <= min_next;
      hour_reg  <= hour_next;
      wday_reg  <= wday_next;
      mday_reg  <= mday_next;
      month_reg <= month_next;
      year_reg  <= year_next;
    end
  end

  // Update strobe for the matcher, raised on the same edge the counters move
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) upd_reg <= 1'b0;
    else upd_reg <= run & tick; // RULE19
  end

  assign cal.sec   = sec_reg;
  assign cal.min   = min_reg;
  assign cal.hour  = hour_reg;
  assign cal.wday  = wday_reg;
  assign cal.mday  = mday_reg;
  assign cal.month = month_reg;
  assign cal.year  = year_reg;
  assign cal.upd   = upd_reg;

  rcm_tick u_tick (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .slow_clock (slow_clock),
    .ckdiv      (ckdiv_reg),
    .run        (run),
    .one_hz     (tick)
  );

  rcm_match u_match (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .alarm_dt   (alarm_reg),
    .alarm_year (alyear_reg),
    .cal        (cal.snk),
    .hit        (hit)
  );

  // Outputs, each from a flip-flop
  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign calendar_enable = en_reg;
  assign one_hz_tick     = tick;
  assign alarm_event     = hit;
endmodule

/* File: verilog/rcm_cfg.svh */
// Offsets, field ranges, reset values and limits of the calendar block.
// Assumes byte addressing on a 32-bit APB with one word per register.
`ifndef RCM_CFG_SVH
`define RCM_CFG_SVH

`define RCM_OFS_NOW     8'h00
`define RCM_OFS_ALARM   8'h04
`define RCM_OFS_PRESET  8'h08
`define RCM_OFS_YEAR    8'h0C
`define RCM_OFS_ALYEAR  8'h10
`define RCM_OFS_PRYEAR  8'h14
`define RCM_OFS_CTRL    8'h18
`define RCM_OFS_RIS     8'h20
`define RCM_OFS_ICR     8'h28

`define RCM_F_SEC       5:0
`define RCM_F_MIN       11:6
`define RCM_F_HOUR      16:12
`define RCM_F_WDAY      19:17
`define RCM_F_MDAY      24:20
`define RCM_F_MONTH     28:25
`define RCM_F_YEAR      13:0
`define RCM_F_CKDIV     14:0
`define RCM_F_CKDEL     25:16
`define RCM_B_ENABLE    26
`define RCM_B_RIS       0

`define RCM_YEAR_RST    14'h2000
`define RCM_ALYEAR_RST  14'h2000
`define RCM_PRYEAR_RST  14'h0000
`define RCM_CKDIV_RST   15'h7FFF
`define RCM_CKDEL_RST   10'h000

`define RCM_SEC_MAX     6'h3B
`define RCM_HOUR_MAX    5'h17
`define RCM_WDAY_MAX    3'h7
`define RCM_MON_MAX     4'hC
`define RCM_MON_FEB     4'h2

`endif

/* File: verilog/rcm_pkg.sv */
// Types shared by the calendar block.
// Assumes rcm_cfg.svh carries all numeric constants.
package rcm_pkg;
  typedef enum logic [1:0] {RCM_STOP, RCM_LOAD, RCM_RUN} rcm_state_t;
endpackage

/* File: verilog/rcm_cal_if.sv */
// Running calendar values passed from the counter to the alarm matcher.
// Assumes both ends sit on core_clk.
`timescale 1ns/1ps
interface rcm_cal_if;
  logic [5:0]  sec;
  logic [5:0]  min;
  logic [4:0]  hour;
  logic [2:0]  wday;
  logic [4:0]  mday;
  logic [3:0]  month;
  logic [13:0] year;
  logic        upd;
  modport src (output sec, min, hour, wday, mday, month, year, upd);
  modport snk (input sec, min, hour, wday, mday, month, year, upd);
endinterface

/* File: verilog/rcm_tick.sv */
// Slow clock synchroniser and divider producing the one second enable.
// Assumes slow_clock is far slower than core_clk.
`timescale 1ns/1ps
module rcm_tick (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        slow_clock,
  input  wire logic [14:0] ckdiv,
  input  wire logic        run,
  output logic             one_hz
);
  logic        s1_reg;
  logic        s2_reg;
  logic        s3_reg;
  logic        lvl_reg;
  logic [14:0] cnt_reg;
  logic        agree;
  logic        rise;
  logic        wrap;

  // A change counts only once the last two stages agree
  assign agree = (s2_reg == s3_reg);
  assign rise  = agree & s3_reg & ~lvl_reg;
  assign wrap  = (cnt_reg == ckdiv);

  // Three-stage synchroniser and settled level
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      lvl_reg <= 1'b0;
    end else begin
      s1_reg  <= slow_clock;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      if (agree) lvl_reg <= s3_reg;
    end
  end

  // Divide by ckdiv plus one; zero stops the calendar tick entirely
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 15'h0000;
      one_hz  <= 1'b0;
    end else begin
      one_hz <= run & rise & wrap & (ckdiv != 15'h0000);
      if (!run) cnt_reg <= 15'h0000;
      else if (rise) cnt_reg <= wrap ? 15'h0000 : cnt_reg + 15'h0001;
    end
  end
endmodule

/* File: verilog/rcm_match.sv */
// Alarm comparator: fires a one-cycle pulse after a matching update.
// Assumes upd pulses in the first cycle the calendar fields show new values.
`timescale 1ns/1ps
`include "rcm_cfg.svh"
module rcm_match (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [28:0] alarm_dt,
  input  wire logic [13:0] alarm_year,
  rcm_cal_if.snk           cal,
  output logic             hit
);
  logic [5:0] al_sec;
  logic [5:0] al_min;
  logic [4:0] al_hour;
  logic [2:0] al_wday;
  logic [4:0] al_mday;
  logic [3:0] al_mon;
  logic       m_time;
  logic       m_wday;
  logic       m_mday;
  logic       m_mon;
  logic       m_all;

  assign al_sec  = alarm_dt[`RCM_F_SEC];
  assign al_min  = alarm_dt[`RCM_F_MIN];
  assign al_hour = alarm_dt[`RCM_F_HOUR];
  assign al_wday = alarm_dt[`RCM_F_WDAY];
  assign al_mday = alarm_dt[`RCM_F_MDAY];
  assign al_mon  = alarm_dt[`RCM_F_MONTH];

  // Out-of-range time alarms never match
  assign m_time = (al_sec <= `RCM_SEC_MAX) && (al_sec == cal.sec) && // RULE16
                  (al_min <= `RCM_SEC_MAX) && (al_min == cal.min) &&
                  (al_hour <= `RCM_HOUR_MAX) && (al_hour == cal.hour);
  assign m_wday = (al_wday == 3'h0) || (al_wday == cal.wday); // RULE1 RULE2
  assign m_mday = (al_mday == 5'h00) || (al_mday == cal.mday); // RULE3 RULE4
  assign m_mon  = (al_mon == 4'h0) ||                       // RULE5
                  ((al_mon <= `RCM_MON_MAX) && (al_mon == cal.month)); // RULE6 RULE7
  assign m_all  = m_time & m_wday & m_mday & m_mon &
                  (alarm_year == cal.year);                 // RULE19

  // Compare only on a fresh one second update
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) hit <= 1'b0;
    else hit <= cal.upd & m_all; // RULE19 RULE6
  end
endmodule

/* File: dv/rcm_top_asserts.sv */
// Port-level checks of the calendar block: APB timing, alarm, lock.
// Assumes it is bound to rcm_top and sees only that module's ports.
`timescale 1ns/1ps
`include "rcm_cfg.svh"
module rcm_chk (
  input logic        core_clk,
  input logic        rstn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        slow_clock,
  input logic        calendar_enable,
  input logic        one_hz_tick,
  input logic        alarm_event
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Read of a given register completing in this cycle
  wire rd_done = psel && penable && pready && !pwrite;

  chk_pready_first: assert property (psel && penable && !$past(penable)
    |-> pready) else $error("pready late");
  chk_pready_once: assert property (pready |=> !pready)
    else $error("pready held");
  chk_err_with_ready: assert property (pslverr |-> pready && psel)
    else $error("pslverr alone");
  chk_unmapped_err: assert property (pready && paddr > `RCM_OFS_ICR
    |-> pslverr && prdata == 32'h0) else $error("unmapped accepted");
  chk_year_reset: assert property (rd_done && !calendar_enable &&
    paddr == `RCM_OFS_YEAR |-> prdata == 32'h00002000)
    else $error("year not at reset value");
  chk_alyear_width: assert property (rd_done &&
    paddr == `RCM_OFS_ALYEAR |-> prdata[31:14] == 18'h0)
    else $error("alarm year upper bits");
  chk_pryear_width: assert property (rd_done &&
    paddr == `RCM_OFS_PRYEAR |-> prdata[31:14] == 18'h0)
    else $error("preset year upper bits");
  chk_alarm_after_tick: assert property (alarm_event
    |-> $past(one_hz_tick, 2)) else $error("alarm without tick");
  chk_alarm_pulse: assert property (alarm_event |=> !alarm_event)
    else $error("alarm held");
  chk_tick_needs_en: assert property (one_hz_tick
    |-> calendar_enable) else $error("tick while stopped");
  chk_enable_sticky: assert property (calendar_enable
    |=> calendar_enable [*2]) else $error("enable dropped");

  // Main scenarios reached
  cov_alarm: cover property (alarm_event);
  cov_error: cover property (pslverr);
  cov_enable: cover property ($rose(calendar_enable));
endmodule

bind rcm_top rcm_chk u_chk (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .slow_clock(slow_clock),
  .calendar_enable(calendar_enable), .one_hz_tick(one_hz_tick),
  .alarm_event(alarm_event));

/* File: dv/rcm_tb.sv */
// Self-checking bench of the calendar block over APB.
// Assumes the slave answers in the first access cycle; slow clock is slow.
`timescale 1ns/1ps
`include "rcm_cfg.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin \
  miscompares++; $display("BAD %0t got %h want %h", $time, a, b); end end
module tb;
  logic        core_clk = 0;
  logic        rstn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        slow_clock = 0;
  logic [31:0] prdata, r;
  logic        pready, pslverr, e, calendar_enable, one_hz_tick, alarm_event;
  int          miscompares = 0;
  int          n_tests = 0;
  int          n_alarm, n_tick;

  rcm_top DUT (.core_clk(core_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_clock(slow_clock), .calendar_enable(calendar_enable),
    .one_hz_tick(one_hz_tick), .alarm_event(alarm_event));

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  // Count output pulses; both are one cycle wide
  always @(posedge core_clk) begin
    if (alarm_event === 1'b1) n_alarm++;
    if (one_hz_tick === 1'b1) n_tick++;
  end

  function automatic logic [31:0] dt(int s, mi, h, w, d, mo);
    return {3'h0, mo[3:0], d[4:0], w[2:0], h[4:0], mi[5:0], s[5:0]};
  endfunction

  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge core_clk); n++; end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK(n, 1)
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    n_alarm = 0;
    n_tick = 0;
  endtask

  // Preset, arm, enable with divider 1, then four slow edges: two ticks
  task automatic run(input logic [31:0] pre, al, input logic [13:0] aly,
                     input int exp);
    do_reset();
    apb(1, `RCM_OFS_PRESET, pre);
    apb(1, `RCM_OFS_PRYEAR, 32'h00002024);
    apb(1, `RCM_OFS_ALARM, al);
    apb(1, `RCM_OFS_ALYEAR, {18'h0, aly});
    apb(1, `RCM_OFS_CTRL, 32'h04000001);
    repeat (4) begin
      repeat (20) @(posedge core_clk);
      slow_clock <= 1'b1;
      repeat (20) @(posedge core_clk);
      slow_clock <= 1'b0;
    end
    repeat (10) @(posedge core_clk);
    `CHK(n_alarm, exp)
    apb(0, `RCM_OFS_RIS, 32'h0);
    `CHK(r[0], exp[0])
  endtask

  localparam logic [31:0] PRE = 32'h08A43140; // 03:05:00 wday2 10 April

  task automatic t_resets();
    apb(0, `RCM_OFS_YEAR, 32'h0);   `CHK(r, 32'h00002000)
    apb(0, `RCM_OFS_ALYEAR, 32'h0); `CHK(r, 32'h00002000)
    apb(0, `RCM_OFS_PRYEAR, 32'h0); `CHK(r, 32'h00000000)
    apb(0, `RCM_OFS_ALARM, 32'h0);  `CHK(r, 32'h00000000)
    apb(1, `RCM_OFS_YEAR, 32'hFFFFFFFF);
    apb(0, `RCM_OFS_YEAR, 32'h0);   `CHK(r, 32'h00002000)
    apb(1, `RCM_OFS_ALYEAR, 32'hFFFFFFFF);
    apb(0, `RCM_OFS_ALYEAR, 32'h0); `CHK(r, 32'h00003FFF)
    apb(1, `RCM_OFS_PRYEAR, 32'hFFFFFFFF);
    apb(0, `RCM_OFS_PRYEAR, 32'h0); `CHK(r, 32'h00003FFF)
    apb(0, 8'h3C, 32'h0);           `CHK({e, r}, 33'h100000000)
  endtask

  task automatic t_weekday();
    run(PRE, dt(1, 5, 3, 0, 0, 0), 14'h2024, 1);
    run(PRE, dt(1, 5, 3, 2, 0, 0), 14'h2024, 1);
    run(PRE, dt(1, 5, 3, 3, 0, 0), 14'h2024, 0);
  endtask

  task automatic t_monthday();
    run(PRE, dt(1, 5, 3, 0, 10, 0), 14'h2024, 1);
    run(PRE, dt(1, 5, 3, 0, 11, 0), 14'h2024, 0);
  endtask

  task automatic t_month();
    run(PRE, dt(1, 5, 3, 0, 0, 4), 14'h2024, 1);
    run(PRE, dt(1, 5, 3, 0, 0, 5), 14'h2024, 0);
    run(PRE, dt(1, 5, 3, 0, 0, 13), 14'h2024, 0);
  endtask

  task automatic t_bad_fields();
    run(PRE, dt(60, 5, 3, 0, 0, 0), 14'h2024, 0);
    run(PRE, dt(1, 5, 24, 0, 0, 0), 14'h2024, 0);
    run(PRE, dt(1, 5, 3, 0, 0, 0), 14'h2025, 0);
  endtask

  // Load, lock and status clear after a matching run
  task automatic t_load_lock();
    run(PRE, dt(1, 5, 3, 2, 10, 4), 14'h2024, 1);
    `CHK(n_tick, 2)
    apb(0, `RCM_OFS_NOW, 32'h0);  `CHK(r, dt(2, 5, 3, 2, 10, 4))
    apb(0, `RCM_OFS_YEAR, 32'h0); `CHK(r, 32'h00002024)
    apb(1, `RCM_OFS_CTRL, 32'h00000005);
    apb(0, `RCM_OFS_CTRL, 32'h0); `CHK(r, 32'h04000001)
    `CHK(calendar_enable, 1'b1)
    apb(1, `RCM_OFS_ICR, 32'h1);
    apb(0, `RCM_OFS_RIS, 32'h0);  `CHK(r, 32'h0)
    // Midnight of the last day of the year: Saturday wraps to Sunday
    run(dt(58, 59, 23, 7, 31, 12), dt(0, 0, 0, 1, 1, 1), 14'h2025, 1);
    apb(0, `RCM_OFS_NOW, 32'h0);  `CHK(r, dt(0, 0, 0, 1, 1, 1))
    apb(0, `RCM_OFS_YEAR, 32'h0); `CHK(r, 32'h00002025)
  endtask

  task automatic test_done();
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run is about 3k cycles; stop a hang well beyond that
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_resets();
    t_weekday();
    t_monthday();
    t_month();
    t_bad_fields();
    t_load_lock();
    test_done();
  end
endmodule
